//--- eies_top.sv
`timescale 1ns/100ps
module eies_top (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic [7:0] g0_event_i,
	input wire logic network_wake_i,
	input wire logic link_change_i,
	input wire logic jabber_i,
	input wire logic negotiation_failed_i,
	input wire logic negotiation_done_i,
	output logic [7:0] host_rdata_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Address match helper
	// ----------------------------------------------------------------
	function automatic logic eies_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] target);
		eies_hit = strobe && (addr == target);
	endfunction

	// ----------------------------------------------------------------
	// State and flag banks
	// ----------------------------------------------------------------
	eies_pkg::eies_top_state_type st;
	eies_pkg::eies_top_state_type next_st;

	eies_flag_if fl0 ();
	eies_flag_if fl1 ();

	logic rd_clear_g0;
	logic rd_clear_g1;
	logic [7:0] g1_events;
	logic [7:0] pending;

	// First group, one flag per event source
	eies_flag_bank u_bank_g0 (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.fb(fl0.bank)
	);

	// Second group, only five flags can ever set
	eies_flag_bank u_bank_g1 (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.fb(fl1.bank)
	);

	// ----------------------------------------------------------------
	// Event routing
	// ----------------------------------------------------------------
	// Unused positions stay low so they always read zero
	always_comb
	begin
		g1_events = 8'h00;
		g1_events[eies_pkg::POS_NETWORK_WAKE] = network_wake_i;
		g1_events[eies_pkg::POS_LINK_CHANGE] = link_change_i;
		g1_events[eies_pkg::POS_JABBER] = jabber_i;
		g1_events[eies_pkg::POS_NEGOTIATION_FAILED] = negotiation_failed_i;
		g1_events[eies_pkg::POS_NEGOTIATION_DONE] = negotiation_done_i;
	end

	// Clear strobes come only from reads of the clearing addresses
	assign rd_clear_g0 = eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_CLEAR_G0);
	assign rd_clear_g1 = eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_CLEAR_G1);

	assign fl0.set = g0_event_i;
	assign fl0.clr = {8{rd_clear_g0}};
	assign fl1.set = g1_events & eies_pkg::G1_MASK;
	assign fl1.clr = {8{rd_clear_g1}};

	// Enabled flags still waiting for service
	assign pending = (fl0.flags & st.irq_enable_group0) | (fl1.flags & st.irq_enable_group1);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		// Enable writes; status addresses ignore writes
		if (eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G0))
			next_st.irq_enable_group0 = host_wdata_i;
		if (eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G1))
			next_st.irq_enable_group1 = host_wdata_i & eies_pkg::G1_MASK;
		// Read data is captured before any clear takes effect
		if (host_rd_i)
		begin
			case (host_addr_i)
				eies_pkg::ADDR_ENABLE_G0: next_st.rdata = st.irq_enable_group0;
				eies_pkg::ADDR_ENABLE_G1: next_st.rdata = st.irq_enable_group1;
				eies_pkg::ADDR_PEEK_G0: next_st.rdata = fl0.flags;
				eies_pkg::ADDR_CLEAR_G0: next_st.rdata = fl0.flags;
				eies_pkg::ADDR_PEEK_G1: next_st.rdata = fl1.flags;
				eies_pkg::ADDR_CLEAR_G1: next_st.rdata = fl1.flags;
				default: next_st.rdata = eies_pkg::UNMAPPED_DATA;
			endcase
		end
		// Each enable bit gates its own flag; request is a level
		next_st.irq = |pending;
	end

	// State register
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			st <= eies_pkg::TOP_RST;
		else
			st <= next_st;
	end

	assign host_rdata_o = st.rdata;
	assign irq_o = st.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// ----------------------------------------------------------------
	// Reset checks and the group 0 enable write check
	// ----------------------------------------------------------------
	// The reset checks look through reset on purpose, so a stuck reset value shows up
	a_enable1_reset: assert property (disable iff (1'b0)
		sys_rst_i |=> (st.irq_enable_group1 == 8'h00))
		else $error("group 1 enable not cleared by reset");

	a_flags_reset: assert property (disable iff (1'b0)
		sys_rst_i |=> ((fl0.flags == 8'h00) && (fl1.flags == 8'h00)))
		else $error("flags not cleared by reset");

	a_irq_reset: assert property (disable iff (1'b0)
		sys_rst_i |=> (!irq_o && (host_rdata_o == 8'h00)))
		else $error("outputs not cleared by reset");

	a_enable0_reset: assert property (disable iff (1'b0)
		sys_rst_i |=> (st.irq_enable_group0 == 8'h00))
		else $error("group 0 enable not cleared by reset");

	a_enable0_write: assert property (
		eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G0)
		|=> (st.irq_enable_group0 == $past(host_wdata_i)))
		else $error("group 0 enable write lost");

	// ----------------------------------------------------------------
	// Gating checks
	// ----------------------------------------------------------------
	a_end_read_gate: assert property (
		(fl0.flags[eies_pkg::POS_PACKET_END_READ] && st.irq_enable_group0[7]) |=> irq_o)
		else $error("end of packet interrupt not raised");

	a_rx_empty_gate: assert property (
		(fl0.flags[eies_pkg::POS_RX_BUFFER_EMPTY] && st.irq_enable_group0[6]) |=> irq_o)
		else $error("buffer empty interrupt not raised");

	a_self_init_gate: assert property (
		(fl0.flags[eies_pkg::POS_SELF_INIT_DONE] && st.irq_enable_group0[5]) |=> irq_o)
		else $error("self init interrupt not raised");

	a_received_gate: assert property (
		(fl0.flags[eies_pkg::POS_PACKET_RECEIVED] && st.irq_enable_group0[0]) |=> irq_o)
		else $error("received interrupt not raised");

	// A cleared enable bit must hide its flag even while the flag stays set
	a_osc_masked: assert property (
		((fl0.flags == 8'h10) && !st.irq_enable_group0[4] && (fl1.flags == 8'h00))
		|=> !irq_o)
		else $error("oscillator interrupt not suppressed");

	a_flash_masked: assert property (
		((fl0.flags == 8'h08) && !st.irq_enable_group0[3] && (fl1.flags == 8'h00))
		|=> !irq_o)
		else $error("flash interrupt not suppressed");

	a_sent_masked: assert property (
		((fl0.flags == 8'h04) && !st.irq_enable_group0[2] && (fl1.flags == 8'h00))
		|=> !irq_o)
		else $error("sent interrupt not suppressed");

	a_full_masked: assert property (
		((fl0.flags == 8'h02) && !st.irq_enable_group0[1] && (fl1.flags == 8'h00))
		|=> !irq_o)
		else $error("buffer full interrupt not suppressed");

	a_wake_gate: assert property (
		(fl1.flags[eies_pkg::POS_NETWORK_WAKE] && st.irq_enable_group1[5]) |=> irq_o)
		else $error("wake interrupt not raised");

	a_link_gate: assert property (
		(fl1.flags[eies_pkg::POS_LINK_CHANGE] && st.irq_enable_group1[4]) |=> irq_o)
		else $error("link interrupt not raised");

	a_jabber_gate: assert property (
		(fl1.flags[eies_pkg::POS_JABBER] && st.irq_enable_group1[3]) |=> irq_o)
		else $error("jabber interrupt not raised");

	a_fail_gate: assert property (
		(fl1.flags[eies_pkg::POS_NEGOTIATION_FAILED] && st.irq_enable_group1[2]) |=> irq_o)
		else $error("negotiation failed interrupt not raised");

	a_done_gate: assert property (
		(fl1.flags[eies_pkg::POS_NEGOTIATION_DONE] && st.irq_enable_group1[0]) |=> irq_o)
		else $error("negotiation done interrupt not raised");

	a_irq_quiet: assert property (
		(((fl0.flags & st.irq_enable_group0) == 8'h00)
		&& ((fl1.flags & st.irq_enable_group1) == 8'h00)) |=> !irq_o)
		else $error("interrupt request without enabled flag");

	a_osc_gate: assert property (
		(fl0.flags[eies_pkg::POS_OSC_INIT_DONE] && st.irq_enable_group0[4]) |=> irq_o)
		else $error("oscillator interrupt not raised");

	a_flash_gate: assert property (
		(fl0.flags[eies_pkg::POS_FLASH_OP_DONE] && st.irq_enable_group0[3]) |=> irq_o)
		else $error("flash interrupt not raised");

	a_sent_gate: assert property (
		(fl0.flags[eies_pkg::POS_PACKET_SENT] && st.irq_enable_group0[2]) |=> irq_o)
		else $error("sent interrupt not raised");

	a_full_gate: assert property (
		(fl0.flags[eies_pkg::POS_RX_BUFFER_FULL] && st.irq_enable_group0[1]) |=> irq_o)
		else $error("buffer full interrupt not raised");

	// ----------------------------------------------------------------
	// Host port and flag checks
	// ----------------------------------------------------------------
	// Software may poll the data late, so it must not move between reads
	a_rdata_holds: assert property (
		!host_rd_i |=> $stable(host_rdata_o))
		else $error("read data changed without a read");

	a_status_writes_ignored: assert property (
		(host_wr_i && !rd_clear_g1 && (g1_events == 8'h00))
		|=> $stable(fl1.flags))
		else $error("write changed status flags");

	a_enable0_keeps: assert property (
		!eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G0)
		|=> $stable(st.irq_enable_group0))
		else $error("group 0 enable changed without write");

	a_enable1_keeps: assert property (
		!eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G1)
		|=> $stable(st.irq_enable_group1))
		else $error("group 1 enable changed without write");

	a_enable0_read: assert property (
		eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_ENABLE_G0)
		|=> (host_rdata_o == $past(st.irq_enable_group0)))
		else $error("group 0 enable read wrong");

	a_enable1_read: assert property (
		eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_ENABLE_G1)
		|=> (host_rdata_o == $past(st.irq_enable_group1)))
		else $error("group 1 enable read wrong");

	a_clear0_read: assert property (
		rd_clear_g0 |=> ((host_rdata_o == $past(fl0.flags))
		&& (fl0.flags == $past(g0_event_i))))
		else $error("group 0 clearing read wrong");

	a_clear_read: assert property (
		rd_clear_g1 |=> ((host_rdata_o == $past(fl1.flags))
		&& (fl1.flags == ($past(g1_events) & 8'h3d))))
		else $error("clearing read wrong");

	a_peek_keeps: assert property (
		(eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_PEEK_G1) && (g1_events == 8'h00))
		|=> $stable(fl1.flags))
		else $error("peek read changed flags");

	a_peek_value: assert property (
		eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_PEEK_G1)
		|=> (host_rdata_o == $past(fl1.flags)))
		else $error("peek data wrong");

	a_wake_set: assert property (
		network_wake_i |=> fl1.flags[5] [*1] ##1 (fl1.flags[5] || $past(rd_clear_g1)))
		else $error("wake flag not sticky");

	a_link_set: assert property (link_change_i |=> fl1.flags[4])
		else $error("link flag not set");

	a_jabber_set: assert property (jabber_i |=> fl1.flags[3])
		else $error("jabber flag not set");

	a_fail_set: assert property (negotiation_failed_i |=> fl1.flags[2])
		else $error("negotiation failed flag not set");

	a_done_set: assert property (negotiation_done_i |=> fl1.flags[0])
		else $error("negotiation done flag not set");

	a_status_high0: assert property (
		(host_rd_i && ((host_addr_i == eies_pkg::ADDR_PEEK_G1)
		|| (host_addr_i == eies_pkg::ADDR_CLEAR_G1))) |=> (host_rdata_o[7:6] == 2'b00))
		else $error("status bits 7:6 not zero");

	a_status_bit1: assert property (fl1.flags[1] == 1'b0)
		else $error("reserved status bit set");

	a_enable1_write: assert property (
		eies_hit(host_wr_i, host_addr_i, eies_pkg::ADDR_ENABLE_G1)
		|=> (st.irq_enable_group1 == ($past(host_wdata_i) & 8'h3d)))
		else $error("group 1 enable write wrong");

	a_peek0_keeps: assert property (
		(eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_PEEK_G0) && (g0_event_i == 8'h00))
		|=> ($stable(fl0.flags) && (host_rdata_o == $past(fl0.flags))))
		else $error("group 0 peek wrong");

	a_irq_level: assert property (1'b1 |=> (irq_o == (|$past(pending))))
		else $error("interrupt request mismatch");

	// ----------------------------------------------------------------
	// Scenario covers
	// ----------------------------------------------------------------
	c_clear_read: cover property (rd_clear_g1 && (fl1.flags != 8'h00));
	c_irq_rise: cover property ($rose(irq_o));
	c_set_on_clear: cover property (rd_clear_g1 && (g1_events != 8'h00));
	c_irq_fall: cover property ($fell(irq_o));
	c_peek_read: cover property (eies_hit(host_rd_i, host_addr_i, eies_pkg::ADDR_PEEK_G1) && (fl1.flags != 8'h00));

endmodule

//--- eies_pkg.sv
// ----------------------------------------------------------------
// Shared constants of the interrupt enable and status block
// ----------------------------------------------------------------
package eies_pkg;

	// ----------------------------------------------------------------
	// Host port offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CLEAR_G0 = 8'h63;
	localparam logic [7:0] ADDR_ENABLE_G0 = 8'h64;
	localparam logic [7:0] ADDR_PEEK_G0 = 8'h76;
	localparam logic [7:0] ADDR_ENABLE_G1 = 8'h7d;
	localparam logic [7:0] ADDR_PEEK_G1 = 8'h7e;
	localparam logic [7:0] ADDR_CLEAR_G1 = 8'h7f;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	// Bits 5, 4, 3, 2 and 0 exist in the second group
	localparam logic [7:0] G1_MASK = 8'h3d;

	// ----------------------------------------------------------------
	// Field positions, first group
	// ----------------------------------------------------------------
	localparam int POS_PACKET_END_READ = 7;
	localparam int POS_RX_BUFFER_EMPTY = 6;
	localparam int POS_SELF_INIT_DONE = 5;
	localparam int POS_OSC_INIT_DONE = 4;
	localparam int POS_FLASH_OP_DONE = 3;
	localparam int POS_PACKET_SENT = 2;
	localparam int POS_RX_BUFFER_FULL = 1;
	localparam int POS_PACKET_RECEIVED = 0;

	// ----------------------------------------------------------------
	// Field positions, second group
	// ----------------------------------------------------------------
	localparam int POS_NETWORK_WAKE = 5;
	localparam int POS_LINK_CHANGE = 4;
	localparam int POS_JABBER = 3;
	localparam int POS_NEGOTIATION_FAILED = 2;
	localparam int POS_NEGOTIATION_DONE = 0;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] irq_enable_group0;
		logic [7:0] irq_enable_group1;
		logic [7:0] rdata;
		logic irq;
	} eies_top_state_type;

	typedef struct packed {
		logic [7:0] flags;
	} eies_bank_state_type;

	localparam eies_top_state_type TOP_RST = '{
		irq_enable_group0: ENABLE_RST,
		irq_enable_group1: ENABLE_RST,
		rdata: RDATA_RST,
		irq: 1'b0
	};

	localparam eies_bank_state_type BANK_RST = '{flags: FLAGS_RST};

endpackage

//--- eies_flag_if.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Carrier between the top and one sticky flag bank
// ----------------------------------------------------------------
interface eies_flag_if;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] flags;

	modport owner (output set, output clr, input flags);
	modport bank (input set, input clr, output flags);
endinterface

//--- eies_flag_bank.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Eight sticky event flags, set wins over clear
// ----------------------------------------------------------------
module eies_flag_bank (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	eies_flag_if.bank fb
);

	eies_pkg::eies_bank_state_type st;
	eies_pkg::eies_bank_state_type next_st;

	// An event in the clearing cycle survives, so no event is lost
	always_comb
	begin
		next_st = st;
		next_st.flags = (st.flags & ~fb.clr) | fb.set;
	end

	// State register
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			st <= eies_pkg::BANK_RST;
		else
			st <= next_st;
	end

	assign fb.flags = st.flags;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_set_wins_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fb.set != 8'h00) |=> ((fb.flags & $past(fb.set)) == $past(fb.set)))
		else $error("flag event lost");

	a_flag_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fb.clr == 8'h00) |=> ((fb.flags & $past(fb.flags)) == $past(fb.flags)))
		else $error("flag dropped without clear");

endmodule

//--- eies_top_end_marker_unused.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Intentionally empty
// ----------------------------------------------------------------

//--- eies_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host processor on the parallel port, one strobe per access
// ----------------------------------------------------------------
module eies_host_model (
	input wire logic sys_clk_i,
	input wire logic [7:0] host_rdata_i,
	output logic host_rd_o,
	output logic host_wr_o,
	output logic [7:0] host_addr_o,
	output logic [7:0] host_wdata_o
);
	// Idle bus carries inverted values so a stale address never looks valid
	initial
	begin
		host_rd_o = 1'b0;
		host_wr_o = 1'b0;
		host_addr_o = 8'hff;
		host_wdata_o = 8'hff;
	end

	// Write: strobe held across one rising edge, released at the next falling edge
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		host_wr_o = 1'b1;
		host_addr_o = a;
		host_wdata_o = d;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		host_wr_o = 1'b0;
		host_addr_o = ~a;
		host_wdata_o = ~d;
	endtask

	// Read: data is registered at the taking edge, sampled half a cycle later
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		host_rd_o = 1'b1;
		host_addr_o = a;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		host_rd_o = 1'b0;
		host_addr_o = ~a;
		d = host_rdata_i;
	endtask
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("ERROR %0t: got %h expected %h", $time, got, exp); \
		end \
	end
// ----------------------------------------------------------------
// Self-checking bench for the interrupt enable and status block
// ----------------------------------------------------------------
module testbench;
	logic sys_clk_i;
	logic sys_rst_i;
	logic host_rd;
	logic host_wr;
	logic [7:0] host_addr;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata;
	logic irq;
	logic [7:0] g0_ev;
	logic [7:0] g1_ev;
	int fail_count;
	int comparisons;
	int cycles;
	int g1_pos[5];

	eies_top eies_top_inst (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.host_rd_i(host_rd),
		.host_wr_i(host_wr),
		.host_addr_i(host_addr),
		.host_wdata_i(host_wdata),
		.g0_event_i(g0_ev),
		.network_wake_i(g1_ev[5]),
		.link_change_i(g1_ev[4]),
		.jabber_i(g1_ev[3]),
		.negotiation_failed_i(g1_ev[2]),
		.negotiation_done_i(g1_ev[0]),
		.host_rdata_o(host_rdata),
		.irq_o(irq)
	);

	eies_host_model eies_host_model_inst (
		.sys_clk_i(sys_clk_i),
		.host_rdata_i(host_rdata),
		.host_rd_o(host_rd),
		.host_wr_o(host_wr),
		.host_addr_o(host_addr),
		.host_wdata_o(host_wdata)
	);

	// 50 ns clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard, well above the few hundred cycles the sequence needs
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		eies_host_model_inst.read_reg(a, d);
		`CHK(d, e)
	endtask

	// One-cycle event pulse, then two cycles for flag and request to settle
	task automatic pulse(input logic [7:0] g0, input logic [7:0] g1);
		@(negedge sys_clk_i);
		g0_ev = g0;
		g1_ev = g1;
		@(negedge sys_clk_i);
		g0_ev = 8'h00;
		g1_ev = 8'h00;
		repeat (2) @(negedge sys_clk_i);
	endtask

	task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
		eies_host_model_inst.write_reg(a, d);
		repeat (2) @(negedge sys_clk_i);
	endtask

	// Main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		g0_ev = 8'h00;
		g1_ev = 8'h00;
		g1_pos = '{eies_pkg::POS_NETWORK_WAKE, eies_pkg::POS_LINK_CHANGE, eies_pkg::POS_JABBER,
			eies_pkg::POS_NEGOTIATION_FAILED, eies_pkg::POS_NEGOTIATION_DONE};
		repeat (4) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		`CHK(irq, 1'b0)
		rd_chk(eies_pkg::ADDR_ENABLE_G0, 8'h00);
		rd_chk(eies_pkg::ADDR_ENABLE_G1, 8'h00);
		rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h00);
		// Reserved enable bits stay zero, status copies ignore writes
		eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G1, 8'hff);
		rd_chk(eies_pkg::ADDR_ENABLE_G1, 8'h3d);
		eies_host_model_inst.write_reg(eies_pkg::ADDR_PEEK_G1, 8'hff);
		rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h00);
		rd_chk(8'h10, eies_pkg::UNMAPPED_DATA);
		eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G1, 8'h00);
		// Each first-group event: masked, then unmasked, then cleared
		for (int b = 0; b < 8; b++)
		begin
			pulse(8'h01 << b, 8'h00);
			`CHK(irq, 1'b0)
			rd_chk(eies_pkg::ADDR_PEEK_G0, 8'h01 << b);
			wr_settle(eies_pkg::ADDR_ENABLE_G0, 8'h01 << b);
			`CHK(irq, 1'b1)
			rd_chk(eies_pkg::ADDR_ENABLE_G0, 8'h01 << b);
			rd_chk(eies_pkg::ADDR_CLEAR_G0, 8'h01 << b);
			repeat (1) @(negedge sys_clk_i);
			`CHK(irq, 1'b0)
			eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G0, 8'h00);
		end
		// Each second-group event with its own enable
		foreach (g1_pos[i])
		begin
			eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G1, 8'h01 << g1_pos[i]);
			pulse(8'h00, 8'h01 << g1_pos[i]);
			`CHK(irq, 1'b1)
			rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h01 << g1_pos[i]);
			rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h01 << g1_pos[i]);
			rd_chk(eies_pkg::ADDR_CLEAR_G1, 8'h01 << g1_pos[i]);
			repeat (1) @(negedge sys_clk_i);
			`CHK(irq, 1'b0)
			rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h00);
		end
		// All second-group events while disabled: no request, one read clears all
		eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G1, 8'h00);
		pulse(8'h00, 8'hff);
		`CHK(irq, 1'b0)
		rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h3d);
		rd_chk(eies_pkg::ADDR_CLEAR_G1, 8'h3d);
		rd_chk(eies_pkg::ADDR_CLEAR_G1, 8'h00);
		// Event in the same cycle as a clearing read survives it
		fork
			rd_chk(eies_pkg::ADDR_CLEAR_G1, 8'h00);
			pulse(8'h00, 8'h08);
		join
		rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h08);
		// Mid-run reset with enables written and flags set
		eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G0, 8'hff);
		eies_host_model_inst.write_reg(eies_pkg::ADDR_ENABLE_G1, 8'hff);
		pulse(8'hff, 8'hff);
		`CHK(irq, 1'b1)
		@(negedge sys_clk_i);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		`CHK(irq, 1'b0)
		rd_chk(eies_pkg::ADDR_ENABLE_G0, 8'h00);
		rd_chk(eies_pkg::ADDR_ENABLE_G1, 8'h00);
		rd_chk(eies_pkg::ADDR_PEEK_G0, 8'h00);
		rd_chk(eies_pkg::ADDR_PEEK_G1, 8'h00);
		final_report();
	end
endmodule
